// ===== logic/rtc_top.sv
// Seconds counter, calibrated second divider and match timer with register slave
`timescale 1ns/1ps
module rtc_top (
    input  wire logic                          CLK_I,              // 125 MHz system clock
    input  wire logic                          RESET_I,            // Synchronous reset, active high
    input  wire logic                          CE_I,               // Clock enable, freezes all state
    input  wire logic                          LFCLK_I,            // 32 kHz slow clock pin
    input  wire logic [rtc_pkg::CAP_PINS-1:0]  CAP_PIN_I,          // Edge capture pins
    input  wire logic [5:0]                    AVS_ADDRESS_I,      // Byte address
    input  wire logic                          AVS_READ_I,         // Read request
    input  wire logic                          AVS_WRITE_I,        // Write request
    input  wire logic [31:0]                   AVS_WRITEDATA_I,    // Write data
    input  wire logic [3:0]                    AVS_BYTEENABLE_I,   // Byte lanes
    output logic      [31:0]                   AVS_READDATA_O,     // Read data
    output logic                               AVS_WAITREQUEST_O,  // Stall
    output logic                               IRQ_O,              // Level interrupt
    output logic                               WAKE_O,             // Wake-up request
    output logic                               CHIP_RST_O          // Chip reset request
);
    import rtc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    bus_state_type         bus_q, bus_d;          // Bus answer state
    logic [31:0]           rdata_q, rdata_d;      // Read data register
    ctrl_type              ctrl_q, ctrl_d;        // Control
    cal_type               cal_q, cal_d;          // Calibration
    logic [EV_W-1:0]       irq_en_q, irq_en_d;    // Interrupt enable
    logic [14:0]           div_q, div_d;          // Second divider
    logic [7:0]            stall_q, stall_d;      // Added calibration cycles
    logic [31:0]           sec_q, sec_d;          // Seconds counter
    logic [31:0]           free_q, free_d;        // Free-running counter
    logic [31:0]           match_q, match_d;      // Match value
    logic                  rst_q, rst_d;          // Chip reset request
    logic                  wake_q, wake_d;        // Wake request
    logic                  lf_rise;               // Slow clock rising edge
    logic [CAP_PINS-1:0]   cap_rise, cap_fall;    // Pin edges
    logic [14:0]           div_top;               // Calibrated last count
    logic                  div_at_top;            // Divider at its last count
    logic                  sec_tick;              // One second elapsed
    logic                  match_ev;              // Free counter hit match
    logic [CAP_PINS-1:0]   cap_ev;                // Selected pin edges
    logic [EV_W-1:0]       events;                // Event pulses
    logic [EV_W-1:0]       clr;                   // Clear pulses
    logic [EV_W-1:0]       status;                // Sticky status
    logic                  irq;                   // Interrupt level
    logic                  acc_done;              // Access completes this edge
    logic                  wr_fire;               // Write takes effect
    logic                  sec_wr;                // Seconds register written

    // Merge write data into old value by byte lanes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Slow clock sampled as a level, rising edge is the count enable
    rtc_sync_edge u_lf_sync (
        .clk_i   (CLK_I),
        .reset_i (RESET_I),
        .ce_i    (CE_I),
        .async_i (LFCLK_I),
        .rise_o  (lf_rise),
        .fall_o  ()
    );

    // One synchroniser per capture pin
    for (genvar g = 0; g < CAP_PINS; g++) begin : g_cap
        rtc_sync_edge u_cap_sync (
            .clk_i   (CLK_I),
            .reset_i (RESET_I),
            .ce_i    (CE_I),
            .async_i (CAP_PIN_I[g]),
            .rise_o  (cap_rise[g]),
            .fall_o  (cap_fall[g])
        );
    end

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    // One wait cycle, then the access completes
    always_comb begin
        bus_d   = bus_q;
        rdata_d = rdata_q;
        case (bus_q)
            BUS_IDLE: begin
                if (AVS_READ_I || AVS_WRITE_I) begin
                    bus_d = BUS_ACK;
                    // Read data ready at the completing edge
                    if (AVS_ADDRESS_I == OFS_CTRL) begin
                        rdata_d = {24'h0, ctrl_q};
                    end else if (AVS_ADDRESS_I == OFS_CAL) begin
                        rdata_d = {16'h0, cal_q.sub, 7'h0, cal_q.amt};
                    end else if (AVS_ADDRESS_I == OFS_SEC) begin
                        rdata_d = sec_q;
                    end else if (AVS_ADDRESS_I == OFS_DIV) begin
                        rdata_d = {17'h0, div_q};
                    end else if (AVS_ADDRESS_I == OFS_FREE) begin
                        rdata_d = free_q;
                    end else if (AVS_ADDRESS_I == OFS_MATCH) begin
                        rdata_d = match_q;
                    end else if (AVS_ADDRESS_I == OFS_STATUS) begin
                        rdata_d = {28'h0, status};
                    end else if (AVS_ADDRESS_I == OFS_IRQ_EN) begin
                        rdata_d = {28'h0, irq_en_q};
                    end else begin
                        // Unmapped and write-only read as zero
                        rdata_d = 32'h0;
                    end
                end
            end
            BUS_ACK: begin
                bus_d = BUS_IDLE;
            end
            default: begin
                bus_d = BUS_IDLE;
            end
        endcase
    end

    // Register bus state
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            bus_q   <= BUS_IDLE;
            rdata_q <= 32'h0;
        end else if (CE_I) begin
            bus_q   <= bus_d;
            rdata_q <= rdata_d;
        end
    end

    assign acc_done          = (bus_q == BUS_ACK);
    assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~acc_done;
    assign AVS_READDATA_O    = rdata_q;
    assign wr_fire           = acc_done & AVS_WRITE_I & CE_I;
    assign sec_wr            = wr_fire && (AVS_ADDRESS_I == OFS_SEC);

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // Writes to control, calibration, match and enable
    always_comb begin
        logic [31:0] m;
        m        = 32'h0;
        ctrl_d   = ctrl_q;
        cal_d    = cal_q;
        match_d  = match_q;
        irq_en_d = irq_en_q;
        clr      = '0;
        if (wr_fire) begin
            if (AVS_ADDRESS_I == OFS_CTRL) begin
                m      = merge({24'h0, ctrl_q}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
                ctrl_d = m[7:0];
            end else if (AVS_ADDRESS_I == OFS_CAL) begin
                m     = merge({16'h0, cal_q.sub, 7'h0, cal_q.amt}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
                cal_d = {m[CAL_SUB_POS], m[7:0]};
            end else if (AVS_ADDRESS_I == OFS_MATCH) begin
                match_d = merge(match_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            end else if (AVS_ADDRESS_I == OFS_IRQ_CLR) begin
                m   = merge(32'h0, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
                clr = m[EV_W-1:0];
            end else if (AVS_ADDRESS_I == OFS_IRQ_EN) begin
                m        = merge({28'h0, irq_en_q}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
                irq_en_d = m[EV_W-1:0];
            end
        end
    end

    // Register software state
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            ctrl_q   <= CTRL_RST;
            cal_q    <= CAL_RST;
            match_q  <= MATCH_RST;
            irq_en_q <= IRQ_EN_RST;
        end else if (CE_I) begin
            ctrl_q   <= ctrl_d;
            cal_q    <= cal_d;
            match_q  <= match_d;
            irq_en_q <= irq_en_d;
        end
    end

    // ------------------------------------------------------------
    // Second divider and seconds counter
    // ------------------------------------------------------------
    // top shortened by amt when sub is set, full top otherwise
    assign div_top    = cal_q.sub ? (DIV_TOP - {7'h0, cal_q.amt}) : DIV_TOP;
    assign div_at_top = (div_q >= div_top);
    // tick at the calibrated top, after the added cycles when sub is clear
    assign sec_tick   = lf_rise & ctrl_q.sec_en & div_at_top & (cal_q.sub | (stall_q == cal_q.amt));

    // Divider, stall and seconds next values
    always_comb begin
        div_d   = div_q;
        stall_d = stall_q;
        sec_d   = sec_q;
        if (lf_rise && ctrl_q.sec_en) begin
            if (sec_tick) begin
                div_d   = 15'h0;
                stall_d = 8'h0;
            end else if (div_at_top) begin
                // hold at top to add cycles
                stall_d = stall_q + 8'h1;
            end else begin
                div_d = div_q + 15'h1;
            end
        end
        // load wins, counting resumes from it
        if (sec_wr) begin
            sec_d = merge(sec_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        end else if (sec_tick) begin
            sec_d = sec_q + 32'h1;
        end
    end

    // Register divider and seconds
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            div_q   <= 15'h0;
            stall_q <= 8'h0;
            sec_q   <= 32'h0;
        end else if (CE_I) begin
            div_q   <= div_d;
            stall_q <= stall_d;
            sec_q   <= sec_d;
        end
    end

    // ------------------------------------------------------------
    // Free-running counter, match and chip reset
    // ------------------------------------------------------------
    // match on the count just reached
    assign match_ev = lf_rise & ctrl_q.free_en & ((free_q + 32'h1) == match_q);

    // Free counter, reset request and wake request
    always_comb begin
        free_d = free_q;
        if (lf_rise && ctrl_q.free_en) begin
            free_d = free_q + 32'h1;
        end
        rst_d  = rst_q | (match_ev & ctrl_q.rst_en);
        wake_d = ctrl_q.wake_en & irq;
    end

    // Register free counter and requests
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            free_q <= 32'h0;
            rst_q  <= 1'b0;
            wake_q <= 1'b0;
        end else if (CE_I) begin
            free_q <= free_d;
            rst_q  <= rst_d;
            wake_q <= wake_d;
        end
    end

    assign CHIP_RST_O = rst_q;
    assign WAKE_O     = wake_q;

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    // selected pin edge
    assign cap_ev = ctrl_q.cap_en & ((ctrl_q.cap_rise & cap_rise) | (~ctrl_q.cap_rise & cap_fall));
    assign events = {cap_ev, match_ev, sec_tick};

    rtc_irq_bank #(
        .W (EV_W)
    ) u_irq (
        .clk_i    (CLK_I),
        .reset_i  (RESET_I),
        .ce_i     (CE_I),
        .event_i  (events),
        .clr_i    (clr),
        .en_i     (irq_en_q),
        .status_o (status),
        .irq_o    (irq)
    );

    assign IRQ_O = irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I || !CE_I);

    property p_div_step;
        (lf_rise && ctrl_q.sec_en && !div_at_top) |=> (div_q == $past(div_q) + 15'h1);
    endproperty
    a_div_step: assert property (p_div_step) else $error("divider did not step");

    property p_sec_irq;
        (sec_tick && irq_en_q[EV_SEC]) |=> status[EV_SEC] && IRQ_O;
    endproperty
    a_sec_irq: assert property (p_sec_irq) else $error("second interrupt missing");

    property p_cal_sub;
        (sec_tick && cal_q.sub) |-> (div_q == DIV_TOP - {7'h0, cal_q.amt});
    endproperty
    a_cal_sub: assert property (p_cal_sub) else $error("shortened period wrong");

    property p_sec_inc;
        (sec_tick && !sec_wr) |=> (sec_q == $past(sec_q) + 32'h1);
    endproperty
    a_sec_inc: assert property (p_sec_inc) else $error("seconds did not count");

    property p_sec_load;
        (sec_wr && AVS_BYTEENABLE_I == 4'hF) |=> (sec_q == $past(AVS_WRITEDATA_I));
    endproperty
    a_sec_load: assert property (p_sec_load) else $error("seconds write lost");

    property p_free_inc;
        (lf_rise && ctrl_q.free_en) |=> (free_q == $past(free_q) + 32'h1);
    endproperty
    a_free_inc: assert property (p_free_inc) else $error("free counter stuck");

    property p_match_irq;
        (match_ev && irq_en_q[EV_MATCH]) |=> status[EV_MATCH] && IRQ_O && (free_q == match_q);
    endproperty
    a_match_irq: assert property (p_match_irq) else $error("match interrupt missing");

    property p_match_rst;
        (match_ev && ctrl_q.rst_en) |=> CHIP_RST_O [*4];
    endproperty
    a_match_rst: assert property (p_match_rst) else $error("chip reset not held");

    property p_wake;
        (IRQ_O && ctrl_q.wake_en) |=> WAKE_O;
    endproperty
    a_wake: assert property (p_wake) else $error("wake request missing");

    property p_cap;
        (cap_fall[1] && ctrl_q.cap_en[1] && !ctrl_q.cap_rise[1]) |=> status[EV_CAP0+1];
    endproperty
    a_cap: assert property (p_cap) else $error("falling edge not captured");

    property p_full_period;
        (sec_tick && !cal_q.sub && cal_q.amt == 8'h00) |-> (div_q == DIV_TOP);
    endproperty
    a_full_period: assert property (p_full_period) else $error("period not 32768");

    c_sec_tick: cover property (sec_tick ##1 IRQ_O);
    c_match_rst: cover property (match_ev && ctrl_q.rst_en);
    c_sec_wr_tick: cover property (sec_wr && sec_tick);
    c_cap_rise: cover property (cap_ev[1] && ctrl_q.cap_rise[1]);
endmodule : rtc_top

// ===== logic/rtc_pkg.sv
// Shared constants, field layouts and types of the seconds and match timer
package rtc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_CTRL    = 6'h00;  // Control bits
    localparam logic [5:0] OFS_CAL     = 6'h04;  // Divider calibration
    localparam logic [5:0] OFS_SEC     = 6'h08;  // Seconds counter
    localparam logic [5:0] OFS_DIV     = 6'h0C;  // Divider value, read only
    localparam logic [5:0] OFS_FREE    = 6'h10;  // Free-running counter, read only
    localparam logic [5:0] OFS_MATCH   = 6'h14;  // Match value
    localparam logic [5:0] OFS_STATUS  = 6'h18;  // Sticky event status, read only
    localparam logic [5:0] OFS_IRQ_CLR = 6'h1C;  // Write one to clear, write only
    localparam logic [5:0] OFS_IRQ_EN  = 6'h20;  // Interrupt enable

    // ------------------------------------------------------------
    // Sizes, positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned CAP_PINS   = 2;       // Edge capture pins
    localparam int unsigned EV_W       = 4;       // Event count
    localparam int unsigned EV_SEC     = 0;       // Second tick event
    localparam int unsigned EV_MATCH   = 1;       // Match event
    localparam int unsigned EV_CAP0    = 2;       // First capture pin event
    localparam int unsigned CAL_SUB_POS = 15;     // Calibration direction bit
    localparam logic [14:0] DIV_TOP    = 15'h7FFF;  // Last divider count, 32768 cycles
    localparam logic [31:0] MATCH_RST  = 32'hFFFFFFFF;  // Match value after reset
    localparam logic [7:0]  CTRL_RST   = 8'h00;  // Control after reset
    localparam logic [8:0]  CAL_RST    = 9'h000; // No calibration after reset
    localparam logic [3:0]  IRQ_EN_RST = 4'h0;   // All interrupts masked

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Control register, bits 7 down to 0
    typedef struct packed {
        logic [1:0] cap_en;    // Capture pin enables
        logic [1:0] cap_rise;  // One: rising edge, zero: falling edge
        logic       wake_en;   // Wake request from interrupts
        logic       rst_en;    // Chip reset on match
        logic       free_en;   // Free-running counter runs
        logic       sec_en;    // Divider and seconds run
    } ctrl_type;

    // Calibration: sub set removes amt cycles, clear adds amt cycles
    typedef struct packed {
        logic       sub;
        logic [7:0] amt;
    } cal_type;

    // Bus answer state
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_type;

endpackage : rtc_pkg

// ===== logic/rtc_sync_edge.sv
// Two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module rtc_sync_edge (
    input  wire logic clk_i,    // System clock
    input  wire logic reset_i,  // Synchronous reset
    input  wire logic ce_i,     // Clock enable
    input  wire logic async_i,  // Asynchronous input
    output logic      rise_o,   // One-cycle pulse on rising edge
    output logic      fall_o    // One-cycle pulse on falling edge
);
    logic [2:0] sync_q;  // Stage 0 meta, 1 stable, 2 delayed
    logic [2:0] sync_d;

    // Shift the input through the stages
    always_comb begin
        sync_d = {sync_q[1:0], async_i};
    end

    // Register stages
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync_q <= 3'h0;
        end else if (ce_i) begin
            sync_q <= sync_d;
        end
    end

    // Edges only from the stable stages
    assign rise_o = sync_q[1] & ~sync_q[2];
    assign fall_o = ~sync_q[1] & sync_q[2];
endmodule : rtc_sync_edge

// ===== logic/rtc_irq_bank.sv
// Sticky event status with enable mask and one level interrupt
`timescale 1ns/1ps
module rtc_irq_bank #(
    parameter int unsigned W = 4  // Event count
) (
    input  wire logic         clk_i,     // System clock
    input  wire logic         reset_i,   // Synchronous reset
    input  wire logic         ce_i,      // Clock enable
    input  wire logic [W-1:0] event_i,   // Event pulses
    input  wire logic [W-1:0] clr_i,     // Clear pulses
    input  wire logic [W-1:0] en_i,      // Enable mask
    output logic      [W-1:0] status_o,  // Sticky status
    output logic              irq_o      // Level interrupt
);
    logic [W-1:0] status_q;
    logic [W-1:0] status_d;
    logic         irq_q;
    logic         irq_d;

    // Set wins over clear in the same cycle
    always_comb begin
        status_d = (status_q & ~clr_i) | event_i;
        irq_d    = |(status_d & en_i);
    end

    // Register status and interrupt
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            status_q <= '0;
            irq_q    <= 1'b0;
        end else if (ce_i) begin
            status_q <= status_d;
            irq_q    <= irq_d;
        end
    end

    assign status_o = status_q;
    assign irq_o    = irq_q;
endmodule : rtc_irq_bank

// ===== dv/rtc_top_test.sv
// Self-checking bench of the seconds and match timer
`timescale 1ns/1ps
module rtc_top_test;
    import rtc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk = 0, rst = 1, lf = 0, ce = 1;      // Clocks, reset, clock enable
    logic [1:0]  pin = 0;                               // Capture pins
    logic [5:0]  adr = 0;                               // Bus address
    logic        rd = 0, wr = 0;                        // Bus strobes
    logic [31:0] wd = 0, rdat, q;                       // Bus data
    logic        wt, irq, wake, crst;                   // Outputs
    int          fail_count = 0, n_compared = 0;        // Counters
    int          n;                                     // Wait count
    int          lf_goal = 0, lf_done = 0;              // Slow edges asked for and made
    // Reset view of every place, read-only and unmapped ones too
    logic [5:0]  ad [10] = '{OFS_CTRL, OFS_CAL, OFS_SEC, OFS_DIV, OFS_FREE, OFS_MATCH,
                             OFS_STATUS, OFS_IRQ_EN, OFS_IRQ_CLR, 6'h24};
    logic [31:0] ex [10] = '{0, 0, 0, 0, 0, MATCH_RST, 0, 0, 0, 0};
    rtc_top rtc_top_inst (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .LFCLK_I(lf), .CAP_PIN_I(pin),
        .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
        .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wt), .IRQ_O(irq),
        .WAKE_O(wake), .CHIP_RST_O(crst));
    // System clock
    initial begin
        forever #4 clk = ~clk;
    end
    // Slow clock: counted rising edges, a period of two system cycles while edges are owed
    always @(posedge clk) begin
        if (lf) begin
            lf <= 0;
        end else if (lf_done != lf_goal) begin
            lf      <= 1;
            lf_done <= lf_done + 1;
        end
    end
    // One bus access, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a; wr <= w; rd <= !w; wd <= d;
        do begin
            @(posedge clk);
        end while (wt !== 1'b0);
        // Read data taken at the completing edge, then the request is released
        q = rdat;
        rd <= 0; wr <= 0;
    endtask : bus
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic rdchk(input string s, input logic [5:0] a, input logic [31:0] e);
        bus(0, a, 0);
        chk(s, e, q);
    endtask : rdchk
    // Wait for the interrupt line under a bound
    task automatic wait_irq(input int lim);
        n = 0;
        while (irq !== 1'b1 && n < lim) begin @(posedge clk); n++; end
        // A wait that runs out is a mismatch
        if (irq !== 1'b1) fail_count++;
    endtask : wait_irq
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        // Reset values, read-only and unmapped places
        bus(1, OFS_FREE, 32'h0000_00AA);
        for (int i = 0; i < 10; i++) rdchk("reset reg", ad[i], ex[i]);
        chk("irq reset", 0, irq);
        $display("test reset done");
        // Free counter reaches match: interrupt, wake and chip reset
        bus(1, OFS_MATCH, 32'h0000_0005);
        bus(1, OFS_IRQ_EN, 32'h0000_0002);
        bus(1, OFS_CTRL, 32'h0000_000E);
        // Clock enable low: slow edges must not move the free counter
        ce <= 0;
        lf_goal <= lf_goal + 3;
        repeat (10) @(posedge clk);
        ce <= 1;
        rdchk("free frozen", OFS_FREE, 32'h0);
        // Exactly five slow edges reach the match value
        lf_goal <= lf_goal + 5;
        wait_irq(200);
        rdchk("match status", OFS_STATUS, 32'h2);
        chk("chip reset", 1, crst);
        chk("wake", 1, wake);
        rdchk("free at match", OFS_FREE, 32'h5);
        bus(1, OFS_CTRL, 0);
        bus(1, OFS_IRQ_CLR, 32'h2);
        rdchk("status cleared", OFS_STATUS, 0);
        chk("irq low", 0, irq);
        $display("test match done");
        // Edges: pin 0 on rising, pin 1 on falling
        bus(1, OFS_IRQ_EN, 32'hC);
        bus(1, OFS_CTRL, 32'hD0);
        pin <= 2'b11;
        repeat (8) @(posedge clk);
        rdchk("rise capture", OFS_STATUS, 32'h4);
        chk("irq capture", 1, irq);
        bus(1, OFS_IRQ_CLR, 32'hC);
        pin <= 2'b00;
        repeat (8) @(posedge clk);
        rdchk("fall capture", OFS_STATUS, 32'h8);
        bus(1, OFS_IRQ_CLR, 32'hC);
        $display("test capture done");
        // Shortened second, seconds written while running
        bus(1, OFS_IRQ_EN, 32'h1);
        bus(1, OFS_CAL, 32'h0000_80FF);
        bus(1, OFS_CTRL, 32'h1);
        bus(1, OFS_SEC, 32'h1234_5678);
        // Slow clock starts now: 32768 - 255 slow periods of two cycles each
        lf_goal <= lf_goal + 40000;
        wait_irq(70000);
        chk("second length ok", 1, n > 65020 && n < 65040);
        rdchk("seconds", OFS_SEC, 32'h1234_5679);
        rdchk("tick status", OFS_STATUS, 32'h1);
        $display("test seconds done");
        give_verdict();
    end
endmodule : rtc_top_test
